// File: include/dds_consts.svh
// Constants for the two-word-burst DDR SRAM port.
// Assumes inclusion by the package and the design file only.
//
// Overview of operation
// - Loop mode: first read word 1.5 cycles after the read command.
// - Loop bypassed: legacy mode, read latency of one cycle.
// - Accesses start only on rising edges of the positive input clock.
// - Write data captured on rising edges of both input clocks.
// - Command inputs sampled only on positive input clock rises; lane inputs on both input clock rises.
// - Every access is a burst of exactly two 18-bit words.
// - Read command latches read address; its LSB feeds the burst counter.
// - One-bit linear burst counter forms the second address.
// - Loop mode: read word one on complementary output edge, word two on next positive.
// - Started reads always finish; a read may start every cycle.
// - Outputs float after the next positive output edge once reads finish.
// - Write command latches write address; its LSB feeds the burst counter.
// - Word one on next positive edge, word two on complement, then commit.
// - A write may start every cycle, one word per input clock edge.
// - Deselected: finish pending writes, then ignore inputs.
// - Lane enables sampled per word; deasserted lanes stay unchanged.
// - Both output clocks high at power on select single-clock mode.
// - Last write is posted and committed on the next write.
// - Reads of a just-written address return posted data; in legacy mode a read in the next cycle gets pre-write data.
// - Outputs timed from output clocks, or input clocks in single mode.
// - Second address equals the first with its LSB inverted.
// - Powers up deselected with data outputs floating.
// - Lane 0 covers bits 8..0, lane 1 bits 17..9.
`ifndef DDS_CONSTS_SVH
`define DDS_CONSTS_SVH
`define DDS_WORD_W    18
`define DDS_LANE_W    9
`define DDS_LANES     2
`define DDS_ADDR_W    21
`define DDS_FIFO_D    8
`define DDS_CTL_W     9
`define DDS_ST_IDLE   2'b00
`define DDS_ST_W1     2'b01
`define DDS_ST_W2     2'b11
`endif

// File: include/dds_pkg.sv
// Types for the two-word-burst DDR SRAM port.
// Assumes dds_consts.svh on the include path.
`include "dds_consts.svh"
package dds_pkg;
  typedef enum logic [1:0]
  {
    DDS_IDLE = `DDS_ST_IDLE,
    DDS_W1   = `DDS_ST_W1,
    DDS_W2   = `DDS_ST_W2
  } dds_out_state_t;
  typedef logic [`DDS_WORD_W-1:0] dds_word_t;
  typedef logic [`DDS_LANES-1:0]  dds_mask_t;
endpackage : dds_pkg

// File: rtl/dds_sram_port.sv
// Write FIFO and the device-side logic of a two-word-burst DDR SRAM port.
// Assumes all pins asynchronous to sys_clk, which runs far above the link clocks.
`timescale 1ns/100ps
`default_nettype none
`include "dds_consts.svh"

module dds_fifo #(
  parameter int W = 8,
  parameter int D = `DDS_FIFO_D
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [PW:0]  wp_r;
  logic [PW:0]  rp_r;
  logic         push;
  logic         pop;

  assign in_ready  = (wp_r - rp_r) != (PW+1)'(D);
  assign out_valid = wp_r != rp_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rp_r[PW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r[PW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule : dds_fifo

////////////////////////////////////////////////////////////////////////////////

module dds_sram_port #(
  parameter int AW = `DDS_ADDR_W
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    in_clk_pos,
  input  wire logic                    in_clk_neg,
  input  wire logic                    out_clk_pos,
  input  wire logic                    out_clk_neg,
  input  wire logic                    pll_bypass_n,
  input  wire logic                    transfer_select_n,
  input  wire logic                    read_not_write,
  input  wire dds_pkg::dds_mask_t      lane_write_enable_n,
  input  wire logic [AW-1:0]           address,
  input  wire dds_pkg::dds_word_t      dq_in,
  output dds_pkg::dds_word_t           dq_out,
  output logic                         dq_oe,
  output logic                         mirror_timing_out,
  output logic                         mirror_timing_out_n,
  output logic                         write_ready
);
  import dds_pkg::*;

  localparam int SW = `DDS_CTL_W + AW + `DDS_WORD_W;
  localparam int EW = AW + 2 * (`DDS_WORD_W + `DDS_LANES);

  dds_word_t      mem [2**AW];
  logic [SW-1:0]  s1_r;
  logic [SW-1:0]  s2_r;
  logic [3:0]     clk_d_r;
  logic [1:0]     strap_cnt_r;
  logic           single_r;
  logic           k_p, k_n, c_p, c_n, bypass_n, ld_n, rnw;
  dds_mask_t      bws_n;
  logic [AW-1:0]  addr_s;
  dds_word_t      d_s;
  logic           kr, kfr, op, on, opr, onr;
  logic           legacy;
  // Write pipeline
  logic           wr_cmd_r;
  logic [AW-1:0]  wr_addr_r;
  logic           wr_half_r;
  logic [AW-1:0]  wd_addr_r;
  dds_word_t      wd_w1_r;
  dds_mask_t      wd_m1_r;
  logic           push;
  logic [EW-1:0]  push_data;
  logic           fifo_ready;
  logic [EW-1:0]  pop_data;
  logic           pop_valid;
  logic           pop_ready;
  // Posted write
  logic           post_v_r;
  logic [AW-1:0]  post_addr_r;
  dds_word_t      post_w1_r, post_w2_r;
  dds_mask_t      post_m1_r, post_m2_r;
  // Read path
  logic           rd_cmd_r;
  logic [AW-1:0]  rd_addr_r;
  logic           load;
  logic           hold_v_r;
  dds_word_t      hold_w1_r, hold_w2_r, p2_r;
  logic           first_edge, second_edge, consume;
  dds_out_state_t st_r;

  function automatic dds_word_t merge(input dds_word_t old_w, input dds_word_t new_w,
                                      input dds_mask_t en_n);
    dds_word_t r;
    r = old_w;
    for (int i = 0; i < `DDS_LANES; i++)
      if (!en_n[i])
        r[i*`DDS_LANE_W +: `DDS_LANE_W] = new_w[i*`DDS_LANE_W +: `DDS_LANE_W];
    return r;
  endfunction : merge

  // Array word overlaid with any posted lanes aimed at the same location
  function automatic dds_word_t fetch(input logic [AW-1:0] a);
    dds_word_t r;
    r = mem[a];
    if (post_v_r && post_addr_r == a)
      r = merge(r, post_w1_r, post_m1_r);
    if (post_v_r && {post_addr_r[AW-1:1], ~post_addr_r[0]} == a)
      r = merge(r, post_w2_r, post_m2_r);
    return r;
  endfunction : fetch

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= '0;
      s2_r <= '0;
    end
    else
    begin
      s1_r <= {in_clk_pos, in_clk_neg, out_clk_pos, out_clk_neg, pll_bypass_n,
               transfer_select_n, read_not_write, lane_write_enable_n, address, dq_in};
      s2_r <= s1_r;
    end
  end

  assign {k_p, k_n, c_p, c_n, bypass_n, ld_n, rnw, bws_n, addr_s, d_s} = s2_r;

  // Strap caught once the synchronisers hold post-reset levels
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_cnt_r <= '0;
      single_r    <= 1'b0;
    end
    else if (strap_cnt_r != 2'h3)
    begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == 2'h2)
        single_r <= c_p & c_n;
    end
  end

  assign op     = single_r ? k_p : c_p;
  assign on     = single_r ? k_n : c_n;
  assign legacy = ~bypass_n;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      clk_d_r <= '0;
    else
      clk_d_r <= {k_p, k_n, op, on};
  end

  assign kr  = k_p & ~clk_d_r[3];
  assign kfr = k_n & ~clk_d_r[2];
  assign opr = op & ~clk_d_r[1];
  assign onr = on & ~clk_d_r[0];

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mirror_timing_out   <= 1'b0;
      mirror_timing_out_n <= 1'b0;
    end
    else
    begin
      mirror_timing_out   <= op;
      mirror_timing_out_n <= on;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write capture: address at t, word one at t+1 rise, word two at t+1 fall

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_cmd_r  <= 1'b0;
      wr_addr_r <= '0;
      wr_half_r <= 1'b0;
      wd_addr_r <= '0;
      wd_w1_r   <= '0;
      wd_m1_r   <= '1;
    end
    else
    begin
      if (kr)
      begin
        wr_cmd_r  <= ~ld_n & ~rnw;
        wr_addr_r <= addr_s;
        wr_half_r <= wr_cmd_r;
        if (wr_cmd_r)
        begin
          wd_addr_r <= wr_addr_r;
          wd_w1_r   <= d_s;
          wd_m1_r   <= bws_n;
        end
      end
      else if (kfr)
        wr_half_r <= 1'b0;
    end
  end

  assign push      = kfr & wr_half_r;
  assign push_data = {wd_addr_r, bws_n, d_s, wd_m1_r, wd_w1_r};

  // Bursts queue here; a full queue drops the burst and shows on write_ready
  dds_fifo #(
    .W (EW),
    .D (`DDS_FIFO_D)
  ) u_wfifo (
    .clk       (sys_clk),
    .rst       (rst),
    .in_data   (push_data),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .out_data  (pop_data),
    .out_valid (pop_valid),
    .out_ready (pop_ready)
  );

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      write_ready <= 1'b0;
    else
      write_ready <= fifo_ready;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Posted write: a new burst pushes the previous one into the array

  // Array has one port; a read load stalls the drain for that cycle
  assign pop_ready = ~load;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      post_v_r    <= 1'b0;
      post_addr_r <= '0;
      post_w1_r   <= '0;
      post_w2_r   <= '0;
      post_m1_r   <= '1;
      post_m2_r   <= '1;
    end
    else if (pop_valid && pop_ready)
    begin
      post_v_r <= 1'b1;
      {post_addr_r, post_m2_r, post_w2_r, post_m1_r, post_w1_r} <= pop_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (pop_valid && pop_ready && post_v_r)
    begin
      mem[post_addr_r] <= merge(mem[post_addr_r], post_w1_r, post_m1_r);
      mem[{post_addr_r[AW-1:1], ~post_addr_r[0]}] <=
        merge(mem[{post_addr_r[AW-1:1], ~post_addr_r[0]}], post_w2_r, post_m2_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read: load the burst half a cycle before its first output edge

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_cmd_r  <= 1'b0;
      rd_addr_r <= '0;
    end
    else if (kr)
    begin
      rd_cmd_r  <= ~ld_n & rnw;
      rd_addr_r <= addr_s;
    end
  end

  assign load = rd_cmd_r & (legacy ? kfr : kr);

  assign first_edge  = legacy ? opr : onr;
  assign second_edge = legacy ? onr : opr;
  assign consume     = first_edge & hold_v_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hold_v_r  <= 1'b0;
      hold_w1_r <= '0;
      hold_w2_r <= '0;
    end
    else
    begin
      hold_v_r <= load | (hold_v_r & ~consume);
      if (load)
      begin
        hold_w1_r <= fetch(rd_addr_r);
        hold_w2_r <= fetch({rd_addr_r[AW-1:1], ~rd_addr_r[0]});
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r   <= DDS_IDLE;
      dq_oe  <= 1'b0;
      dq_out <= '0;
      p2_r   <= '0;
    end
    else
    begin
      case (st_r)
        DDS_IDLE, DDS_W2:
        begin
          if (consume)
          begin
            st_r   <= DDS_W1;
            dq_oe  <= 1'b1;
            dq_out <= hold_w1_r;
            p2_r   <= hold_w2_r;
          end
          else if (opr && st_r == DDS_W2)
          begin
            st_r  <= DDS_IDLE;
            dq_oe <= 1'b0;
          end
        end
        DDS_W1:
        begin
          if (second_edge)
          begin
            st_r   <= DDS_W2;
            dq_out <= p2_r;
          end
        end
        default:
        begin
          st_r  <= DDS_IDLE;
          dq_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule : dds_sram_port
`default_nettype wire

// File: verification/dds_sram_port_assertions.sv
// Pin checker for the DDR SRAM port.
// Assumes a bind onto dds_sram_port and free-running link clocks.
`timescale 1ns/100ps
`default_nettype none
module dds_sram_port_assertions
  import dds_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      rst,
  input wire logic      in_clk_pos,
  input wire logic      out_clk_pos,
  input wire logic      out_clk_neg,
  input wire logic      transfer_select_n,
  input wire logic      read_not_write,
  input wire dds_word_t dq_out,
  input wire logic      dq_oe,
  input wire logic      mirror_timing_out,
  input wire logic      mirror_timing_out_n,
  input wire logic      write_ready
);
  logic       kp_r;
  logic [4:0] rd_age_r;
  wire        rd_cmd = in_clk_pos && !kp_r && !transfer_select_n && read_not_write;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      kp_r <= 1'b0;
    else
      kp_r <= in_clk_pos;
  end
  // Cycles since the last read command, saturating
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rd_age_r <= 5'h1F;
    else if (rd_cmd)
      rd_age_r <= 5'h00;
    else if (rd_age_r != 5'h1F)
      rd_age_r <= rd_age_r + 5'h01;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_rd_cmd;
    rd_cmd;
  endsequence
  sequence s_burst;
    dq_oe [*8];
  endsequence
  a_read_answer: assert property (s_rd_cmd |-> ##[8:20] dq_oe)
    else $error("read not answered in time");
  a_oe_cause: assert property ($rose(dq_oe) |-> rd_age_r inside {[5'h06:5'h14]})
    else $error("data driven without a read");
  a_burst_len: assert property ($rose(dq_oe) |-> s_burst)
    else $error("burst shorter than two words");
  a_word_stands: assert property ($rose(dq_oe) |=> $stable(dq_out) [*3])
    else $error("first word unstable");
  a_idle_float: assert property (rd_age_r > 5'h1A |-> !dq_oe)
    else $error("outputs driven while idle");
  a_reset_float: assert property ($fell(rst) |-> !dq_oe)
    else $error("outputs driven after reset");
  a_ready_up: assert property ($fell(rst) |-> ##[0:2] write_ready)
    else $error("write path not ready");
  a_echo_pos: assert property ($rose(out_clk_pos) |-> ##[2:5] mirror_timing_out)
    else $error("echo clock missing");
  a_echo_neg: assert property ($rose(out_clk_neg) |-> ##[2:5] mirror_timing_out_n)
    else $error("inverse echo clock missing");
endmodule : dds_sram_port_assertions
`default_nettype wire

// File: verification/dds_ctl_model.sv
// Memory controller model driving the link side of the SRAM port.
// Assumes an 8-cycle link period derived from sys_clk.
`timescale 1ns/100ps
`default_nettype none
module dds_ctl_model
  import dds_pkg::*;
#(
  parameter int AW = 4
) (
  input  wire logic      sys_clk,
  input  wire logic      strap_single,
  input  wire dds_word_t dq_out,
  input  wire logic      dq_oe,
  output logic           in_clk_pos,
  output logic           in_clk_neg,
  output logic           out_clk_pos,
  output logic           out_clk_neg,
  output logic           transfer_select_n,
  output logic           read_not_write,
  output dds_mask_t      lane_write_enable_n,
  output logic [AW-1:0]  address,
  output dds_word_t      dq_in
);
  logic [2:0] ph = 3'h0;
  wire  [2:0] nph = ph + 3'h1;
  initial
  begin
    {in_clk_pos, in_clk_neg, out_clk_pos, out_clk_neg} = 4'h0;
    transfer_select_n = 1'b1;
    read_not_write = 1'b1;
    lane_write_enable_n = 2'h3;
    address = '0;
    dq_in = '0;
  end
  // Free running pairs, output pair held high when strapped; positive clocks rise at phase 0
  always @(posedge sys_clk)
  begin
    ph <= nph;
    in_clk_pos <= ~nph[2];
    in_clk_neg <= nph[2];
    // Strap holds the output pair high so the block runs from the input pair
    out_clk_pos <= strap_single | ~nph[2];
    out_clk_neg <= strap_single | nph[2];
  end
  task at(input logic [2:0] k);
    do @(posedge sys_clk); while (ph != k);
  endtask : at
  // Commands change mid-cycle so they are steady across the K rise
  task wr(input logic [AW-1:0] a, input dds_word_t w1, w2, input dds_mask_t m1, m2);
    at(3'h5);
    transfer_select_n <= 1'b0;
    read_not_write <= 1'b0;
    address <= a;
    at(3'h5);
    transfer_select_n <= 1'b1;
    address <= ~a;
    dq_in <= w1;
    lane_write_enable_n <= m1;
    at(3'h1);
    dq_in <= w2;
    lane_write_enable_n <= m2;
    at(3'h5);
    dq_in <= ~w2;
    lane_write_enable_n <= ~m2;
  endtask : wr
  // Callers leave idle cycles before any following write
  task rd(input logic [AW-1:0] a, output dds_word_t w1, w2, output int lat);
    at(3'h5);
    transfer_select_n <= 1'b0;
    read_not_write <= 1'b1;
    address <= a;
    at(3'h7);
    lat = 0;
    do
    begin
      @(posedge sys_clk);
      lat++;
      if (lat == 6)
        transfer_select_n <= 1'b1;
    end
    while (dq_oe !== 1'b1 && lat < 40);
    repeat (2) @(posedge sys_clk);
    w1 = dq_out;
    repeat (4) @(posedge sys_clk);
    w2 = dq_out;
  endtask : rd
endmodule : dds_ctl_model
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the DDR SRAM port.
// Assumes the controller model and checker files are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dds_pkg::*;
  localparam int AW = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic pll_bypass_n = 1'b1;
  logic strap_single = 1'b0;
  logic in_clk_pos, in_clk_neg, out_clk_pos, out_clk_neg;
  logic transfer_select_n, read_not_write, dq_oe, write_ready;
  dds_mask_t lane_write_enable_n;
  logic [AW-1:0] address;
  dds_word_t dq_in, dq_out, r1, r2;
  dds_word_t mem [16];
  int mismatches = 0;
  int checked = 0;
  int lat_n, lat_l;
  always #25 sys_clk = ~sys_clk;
  dds_sram_port #(.AW(AW)) dut (.sys_clk, .rst, .in_clk_pos, .in_clk_neg, .out_clk_pos,
    .out_clk_neg, .pll_bypass_n, .transfer_select_n, .read_not_write, .lane_write_enable_n,
    .address, .dq_in, .dq_out, .dq_oe, .mirror_timing_out(), .mirror_timing_out_n(),
    .write_ready);
  dds_ctl_model #(.AW(AW)) ctl (.sys_clk, .strap_single, .dq_out, .dq_oe, .in_clk_pos, .in_clk_neg,
    .out_clk_pos, .out_clk_neg, .transfer_select_n, .read_not_write, .lane_write_enable_n,
    .address, .dq_in);
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input dds_word_t exp, got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  function automatic dds_word_t mg(dds_word_t o, dds_word_t n, dds_mask_t m);
    return {m[1] ? o[17:9] : n[17:9], m[0] ? o[8:0] : n[8:0]};
  endfunction : mg
  task wr(input logic [AW-1:0] a, input dds_word_t w1, w2, input dds_mask_t m1, m2);
    ctl.wr(a, w1, w2, m1, m2);
    mem[a] = mg(mem[a], w1, m1);
    mem[{a[AW-1:1], ~a[0]}] = mg(mem[{a[AW-1:1], ~a[0]}], w2, m2);
  endtask : wr
  task rd(input logic [AW-1:0] a, input string nm);
    ctl.rd(a, r1, r2, lat_l);
    chk(nm, mem[a], r1);
    chk(nm, mem[{a[AW-1:1], ~a[0]}], r2);
  endtask : rd
  task complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("dq_oe", 18'h0, {17'h0, dq_oe});
    chk("write_ready", 18'h1, {17'h0, write_ready});
    wr(4'h4, 18'h2A5C3, 18'h15A3C, 2'h0, 2'h0);
    rd(4'h4, "posted");
    wr(4'h7, 18'h3C0F1, 18'h0F3C2, 2'h0, 2'h0);
    rd(4'h6, "odd_start");
    rd(4'h4, "array");
    wr(4'h4, 18'h12345, 18'h2BCDE, 2'h1, 2'h2);
    wr(4'h6, 18'h3FFFF, 18'h3FFFF, 2'h3, 2'h3);
    rd(4'h4, "lanes");
    rd(4'h6, "no_lanes");
    lat_n = lat_l;
    pll_bypass_n <= 1'b0;
    rd(4'h4, "legacy");
    chk("latency", 18'h4, 18'(lat_n - lat_l));
    // Second reset with the single-clock strap; posted state is lost, array kept
    pll_bypass_n <= 1'b1;
    strap_single <= 1'b1;
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("dq_oe_rst2", 18'h0, {17'h0, dq_oe});
    rd(4'h4, "single");
    complete_run();
  end
endmodule : tb_top
bind dds_sram_port dds_sram_port_assertions u_chk (.sys_clk, .rst, .in_clk_pos, .out_clk_pos,
  .out_clk_neg, .transfer_select_n, .read_not_write, .dq_out, .dq_oe, .mirror_timing_out,
  .mirror_timing_out_n, .write_ready);
`default_nettype wire
